/* verilog/pci_cache_command_selector.sv */
// Behaviour
// - write-invalidate needs cache, write-invalidate, command-bit enables
// - write-invalidate needs legal line within burst size
// - write-invalidate needs a full line buffered
// - all conditions plus alignment select write-invalidate
// - burst is largest line multiple within cap
// - recompute burst length after every burst
// - latency expiry waits for line boundary in write-invalidate only
// - retry releases, rerequests, reuses write-invalidate
// - disconnect releases; write-invalidate again only aligned
// - cache off: read line for non-fetch reads when read line enabled
// - cache on: read line under full conditions
// - read multiple needs legal aligned two lines
// - read multiple length largest line multiple
// - read multiple wins over read line
// - read multiple works without read line
// - burst equal line gives single lines
// - never originate unsupported PCI commands
// - line size is min(pow2 floor, burst)
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module pci_cache_command_selector
    import cache_cmd_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic                  req_valid,
    input  wire xfer_req_t             req,
    output logic                       req_ready,
    input  wire logic [LEN_W-1:0]      fifo_dwords,
    input  wire bus_event_t            bus_ev,
    output logic                       bus_req,
    output logic                       burst_valid,
    output burst_t                     burst,
    output logic                       bus_release,
    output logic                       xfer_done
);
    if (CNT_W < LEN_W + 1) begin : g_width_check
        $error("CNT_W too narrow for the largest burst");
    end

    function automatic logic [LEN_W-1:0] pow2_floor(input logic [7:0] v);
        logic [LEN_W-1:0] r;
        r = '0;
        for (int i = 1; i < 8; i++) begin
            if (v[i]) begin
                r = BURST_BASE << (i - 1);
            end
        end
        return r;
    endfunction

    function automatic logic [LEN_W-1:0] min_len(input logic [LEN_W-1:0] a, input logic [LEN_W-1:0] b);
        return (a < b) ? a : b;
    endfunction

    // Register file
    logic                  wie_q, next_wie;
    logic [7:0]            dma_mode_register_q, next_dma_mode_register;
    logic [7:0]            tc5_q, next_tc5;
    logic [7:0]            pcicmd_q, next_pcicmd;
    logic [7:0]            cls_q, next_cls;
    logic                  cache_en_q, next_cache_en;
    logic                  aw_got, next_aw_got;
    logic                  w_got, next_w_got;
    logic [AXI_ADDR_W-1:0] waddr_q, next_waddr;
    logic [31:0]           wdata_q, next_wdata;
    logic [3:0]            wstrb_q, next_wstrb;
    logic                  next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]            next_bresp, next_rresp;
    logic [31:0]           next_rdata;

    // Sequencer
    seq_state_t        state, next_state;
    logic [ADDR_W-1:0] addr_q, next_addr;
    logic [CNT_W-1:0]  rem_q, next_rem;
    logic [LEN_W-1:0]  cnt_q, next_cnt;
    logic              is_write_q, next_is_write;
    logic              is_fetch_q, next_is_fetch;
    logic              force_mwi, next_force;
    logic              lat_pend, next_lat;
    logic              rel_latency, next_rel_latency;
    logic              rel_retry, next_rel_retry;
    logic              next_bus_req, next_burst_valid, next_release, next_done, next_req_ready;
    burst_t            next_burst, sel;

    // Cache line and burst size evaluation
    logic [LEN_W-1:0] burst_dw, floor_dw, eff, mask, cap, multiple;
    logic             legal, aligned, mwi_ok, mrm_ok, mrl_ok;

    always_comb begin
        burst_dw = BURST_BASE << {tc5_q[BIT_BURST_EXTEND], dma_mode_register_q[BURST_CODE_LO +: 2]};
        floor_dw = pow2_floor(cls_q);
        legal    = ({1'b0, cls_q} == floor_dw) && (floor_dw != '0) && (floor_dw <= burst_dw);
        eff      = (floor_dw == '0) ? '0 : min_len(floor_dw, burst_dw);
        mask     = eff - 9'h001;
        aligned  = (eff != '0) && ((addr_q[LEN_W-1:0] & mask) == '0);
        cap      = (rem_q >= CNT_W'(burst_dw)) ? burst_dw : rem_q[LEN_W-1:0];
        multiple = cap & ~mask;
        mwi_ok   = cache_en_q && wie_q && pcicmd_q[BIT_MWI_MODE]
                   && legal && (fifo_dwords >= eff) && (rem_q >= CNT_W'(eff))
                   && (aligned || force_mwi);
        mrm_ok   = cache_en_q && dma_mode_register_q[BIT_READ_MULTIPLE_ENABLE] && legal && aligned
                   && (rem_q >= CNT_W'({eff, 1'b0}));
        mrl_ok   = cache_en_q && dma_mode_register_q[BIT_READ_LINE_ENABLE] && legal && aligned
                   && (rem_q >= CNT_W'(burst_dw));
        sel.cmd  = CMD_MEM_READ;
        sel.len  = cap;
        if (is_write_q) begin
            if (mwi_ok) begin
                sel.cmd = CMD_WRITE_INVALIDATE;
                sel.len = multiple;
            end else begin
                sel.cmd = CMD_MEM_WRITE;
                if (cache_en_q) begin
                    sel.len = (aligned && cap >= eff) ? eff : 9'h001;
                end
            end
        end else if (!is_fetch_q) begin
            if (!cache_en_q) begin
                sel.cmd = dma_mode_register_q[BIT_READ_LINE_ENABLE] ? CMD_READ_LINE : CMD_MEM_READ;
            end else if (mrm_ok) begin
                sel.cmd = CMD_READ_MULTIPLE;
                sel.len = multiple;
            end else if (mrl_ok) begin
                sel.cmd = CMD_READ_LINE;
                sel.len = eff;
            end else begin
                sel.len = (aligned && cap >= eff) ? eff : 9'h001;
            end
        end
    end

    logic [ADDR_W-1:0] step_addr;
    logic [CNT_W-1:0]  step_rem;
    logic [LEN_W-1:0]  step_cnt;
    logic              boundary, lat_now, is_mwi;

    always_comb begin
        next_state       = state;
        next_addr        = addr_q;
        next_rem         = rem_q;
        next_cnt         = cnt_q;
        next_is_write    = is_write_q;
        next_is_fetch    = is_fetch_q;
        next_force       = force_mwi;
        next_lat         = lat_pend;
        next_rel_latency = rel_latency;
        next_rel_retry   = rel_retry;
        next_bus_req     = bus_req;
        next_burst_valid = 1'b0;
        next_burst       = burst;
        next_release     = 1'b0;
        next_done        = 1'b0;
        step_addr        = addr_q + ADDR_W'(bus_ev.beat);
        step_rem         = rem_q - CNT_W'(bus_ev.beat);
        step_cnt         = cnt_q - LEN_W'(bus_ev.beat);
        boundary         = (step_addr[LEN_W-1:0] & mask) == '0;
        lat_now          = lat_pend || bus_ev.latency_expired;
        is_mwi           = burst.cmd == CMD_WRITE_INVALIDATE;
        case (state)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    next_addr     = req.addr;
                    next_rem      = req.dwords;
                    next_is_write = req.is_write;
                    next_is_fetch = req.is_fetch;
                    next_force    = 1'b0;
                    if (req.dwords == '0) begin
                        next_done = 1'b1;
                    end else begin
                        next_state   = ST_ISSUE;
                        next_bus_req = 1'b1;
                    end
                end
            end
            ST_ISSUE: begin
                next_burst_valid = 1'b1;
                next_burst       = sel;
                next_cnt         = sel.len;
                next_force       = 1'b0;
                next_lat         = 1'b0;
                next_rel_latency = 1'b0;
                next_rel_retry   = 1'b0;
                next_state       = ST_XFER;
            end
            ST_XFER: begin
                next_addr = step_addr;
                next_rem  = step_rem;
                next_cnt  = step_cnt;
                next_lat  = lat_now;
                if (bus_ev.retry || bus_ev.disconnect || (lat_now && (!is_mwi || boundary))
                    || step_cnt == '0) begin
                    if (step_rem == '0) begin
                        next_state   = ST_IDLE;
                        next_bus_req = 1'b0;
                        next_done    = 1'b1;
                    end else if (!bus_ev.retry && !bus_ev.disconnect && !lat_now) begin
                        next_state = ST_ISSUE;
                    end else begin
                        next_state       = ST_RELEASE;
                        next_release     = 1'b1;
                        next_bus_req     = 1'b0;
                        next_force       = bus_ev.retry && is_mwi;
                        next_rel_retry   = bus_ev.retry;
                        next_rel_latency = !bus_ev.retry && !bus_ev.disconnect;
                    end
                end
            end
            ST_RELEASE: begin
                next_state   = ST_ISSUE;
                next_bus_req = 1'b1;
            end
            default: begin
                next_state   = ST_IDLE;
                next_bus_req = 1'b0;
            end
        endcase
        next_req_ready = next_state == ST_IDLE;
    end

    // AXI4-Lite slave; address and data may arrive in either order
    always_comb begin
        next_wie      = wie_q;
        next_dma_mode_register    = dma_mode_register_q;
        next_tc5      = tc5_q;
        next_pcicmd   = pcicmd_q;
        next_cls      = cls_q;
        next_cache_en = cache_en_q;
        next_aw_got   = aw_got || (awvalid && awready);
        next_w_got    = w_got || (wvalid && wready);
        next_waddr    = (awvalid && awready) ? awaddr : waddr_q;
        next_wdata    = (wvalid && wready) ? wdata : wdata_q;
        next_wstrb    = (wvalid && wready) ? wstrb : wstrb_q;
        next_bvalid   = bvalid && !bready;
        next_bresp    = bresp;
        next_rvalid   = rvalid && !rready;
        next_rdata    = rdata;
        next_rresp    = rresp;
        if (next_aw_got && next_w_got && !next_bvalid) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = RESP_OKAY;
            case (next_waddr)
                OFS_TEST_CONTROL_THREE: if (next_wstrb[0]) next_wie = next_wdata[BIT_WRITE_INVALIDATE_ENABLE];
                OFS_DMA_MODE:           if (next_wstrb[0]) next_dma_mode_register = next_wdata[7:0];
                OFS_TEST_CONTROL_FIVE:  if (next_wstrb[0]) next_tc5 = next_wdata[7:0];
                OFS_PCI_COMMAND:        if (next_wstrb[0]) next_pcicmd = next_wdata[7:0];
                OFS_CACHE_LINE_SIZE:    if (next_wstrb[0]) next_cls = next_wdata[7:0];
                OFS_CACHE_CONTROL:      if (next_wstrb[0]) next_cache_en = next_wdata[BIT_CACHE_MODE_ENABLE];
                OFS_STATUS:             next_bresp = RESP_OKAY;
                default:                next_bresp = RESP_SLVERR;
            endcase
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = '0;
            case (araddr)
                OFS_TEST_CONTROL_THREE: next_rdata[BIT_WRITE_INVALIDATE_ENABLE] = wie_q;
                OFS_DMA_MODE:           next_rdata[7:0] = dma_mode_register_q;
                OFS_TEST_CONTROL_FIVE:  next_rdata[7:0] = tc5_q;
                OFS_PCI_COMMAND:        next_rdata[7:0] = pcicmd_q;
                OFS_CACHE_LINE_SIZE:    next_rdata[7:0] = cls_q;
                OFS_CACHE_CONTROL:      next_rdata[BIT_CACHE_MODE_ENABLE] = cache_en_q;
                OFS_STATUS: begin
                    next_rdata[STAT_CMD_LO +: 4]     = burst.cmd;
                    next_rdata[STAT_LEN_LO +: LEN_W] = burst.len;
                    next_rdata[STAT_BUSY]            = state != ST_IDLE;
                    next_rdata[STAT_LINE_LO +: LEN_W] = eff;
                end
                default:                next_rresp = RESP_SLVERR;
            endcase
        end
        next_awready = !next_aw_got && !next_bvalid;
        next_wready  = !next_w_got && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wie_q <= 1'b0; dma_mode_register_q <= 8'h00; tc5_q <= 8'h00; pcicmd_q <= 8'h00;
            cls_q <= 8'h00; cache_en_q <= 1'b0; aw_got <= 1'b0; w_got <= 1'b0;
            waddr_q <= '0; wdata_q <= 32'h00000000; wstrb_q <= 4'h0;
            awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0; bresp <= RESP_OKAY;
            arready <= 1'b0; rvalid <= 1'b0; rdata <= 32'h00000000; rresp <= RESP_OKAY;
            state <= ST_IDLE; addr_q <= '0; rem_q <= '0; cnt_q <= '0;
            is_write_q <= 1'b0; is_fetch_q <= 1'b0; force_mwi <= 1'b0; lat_pend <= 1'b0;
            rel_latency <= 1'b0; rel_retry <= 1'b0; bus_req <= 1'b0; burst_valid <= 1'b0;
            burst <= '{cmd: CMD_MEM_READ, len: '0}; bus_release <= 1'b0; xfer_done <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            wie_q <= next_wie; dma_mode_register_q <= next_dma_mode_register; tc5_q <= next_tc5; pcicmd_q <= next_pcicmd;
            cls_q <= next_cls; cache_en_q <= next_cache_en; aw_got <= next_aw_got; w_got <= next_w_got;
            waddr_q <= next_waddr; wdata_q <= next_wdata; wstrb_q <= next_wstrb;
            awready <= next_awready; wready <= next_wready; bvalid <= next_bvalid; bresp <= next_bresp;
            arready <= next_arready; rvalid <= next_rvalid; rdata <= next_rdata; rresp <= next_rresp;
            state <= next_state; addr_q <= next_addr; rem_q <= next_rem; cnt_q <= next_cnt;
            is_write_q <= next_is_write; is_fetch_q <= next_is_fetch; force_mwi <= next_force;
            lat_pend <= next_lat; rel_latency <= next_rel_latency; rel_retry <= next_rel_retry;
            bus_req <= next_bus_req; burst_valid <= next_burst_valid; burst <= next_burst;
            bus_release <= next_release; xfer_done <= next_done; req_ready <= next_req_ready;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_mwi_enables;
        burst_valid && burst.cmd == CMD_WRITE_INVALIDATE |-> cache_en_q && wie_q && pcicmd_q[BIT_MWI_MODE];
    endproperty
    a_mwi_enables: assert property (p_mwi_enables) else $error("write-invalidate without enables");

    property p_mwi_sizes;
        burst_valid && burst.cmd == CMD_WRITE_INVALIDATE |-> $past(legal) && $past(fifo_dwords) >= $past(eff);
    endproperty
    a_mwi_sizes: assert property (p_mwi_sizes) else $error("write-invalidate size check failed");

    property p_write_cmd;
        burst_valid && is_write_q |-> burst.cmd == ($past(mwi_ok) ? CMD_WRITE_INVALIDATE : CMD_MEM_WRITE);
    endproperty
    a_write_cmd: assert property (p_write_cmd) else $error("wrong write command");

    property p_multiple_len;
        burst_valid && (burst.cmd == CMD_WRITE_INVALIDATE || burst.cmd == CMD_READ_MULTIPLE)
            |-> (burst.len & mask) == '0 && burst.len != '0 && burst.len <= burst_dw && CNT_W'(burst.len) <= rem_q;
    endproperty
    a_multiple_len: assert property (p_multiple_len) else $error("bad multiple-line length");

    property p_latency_boundary;
        bus_release && rel_latency && burst.cmd == CMD_WRITE_INVALIDATE |-> (addr_q[LEN_W-1:0] & mask) == '0;
    endproperty
    a_latency_boundary: assert property (p_latency_boundary) else $error("released mid-line");

    sequence s_rerequest;
        bus_req ##1 burst_valid;
    endsequence
    property p_retry_reuse;
        bus_release && rel_retry && burst.cmd == CMD_WRITE_INVALIDATE
            |=> s_rerequest ##0 burst.cmd == CMD_WRITE_INVALIDATE;
    endproperty
    a_retry_reuse: assert property (p_retry_reuse) else $error("retry lost write-invalidate");

    property p_rerequest;
        bus_release |=> s_rerequest;
    endproperty
    a_rerequest: assert property (p_rerequest) else $error("no rerequest after release");

    property p_read_line_nocache;
        burst_valid && !is_write_q && !is_fetch_q && !cache_en_q && dma_mode_register_q[BIT_READ_LINE_ENABLE]
            |-> burst.cmd == CMD_READ_LINE;
    endproperty
    a_read_line_nocache: assert property (p_read_line_nocache) else $error("read line missing");

    property p_read_multiple;
        burst_valid && burst.cmd == CMD_READ_MULTIPLE
            |-> dma_mode_register_q[BIT_READ_MULTIPLE_ENABLE] && $past(mrm_ok) && !is_fetch_q;
    endproperty
    a_read_multiple: assert property (p_read_multiple) else $error("read multiple unjustified");

    property p_legal_cmd;
        burst_valid |-> burst.cmd inside {CMD_MEM_READ, CMD_MEM_WRITE, CMD_READ_MULTIPLE,
                                          CMD_READ_LINE, CMD_WRITE_INVALIDATE};
    endproperty
    a_legal_cmd: assert property (p_legal_cmd) else $error("unsupported command issued");

    property p_line_size;
        (eff & mask) == '0 && eff <= burst_dw && eff <= floor_dw;
    endproperty
    a_line_size: assert property (p_line_size) else $error("bad effective line size");
endmodule

/* shared/cache_cmd_pkg.sv */
package cache_cmd_pkg;
    localparam int AXI_ADDR_W = 8;
    localparam int ADDR_W     = 30;
    localparam int CNT_W      = 16;
    localparam int LEN_W      = 9;

    // PCI bus command codes driven during the address phase
    typedef enum logic [3:0] {
        CMD_MEM_READ         = 4'h6,
        CMD_MEM_WRITE        = 4'h7,
        CMD_READ_MULTIPLE    = 4'hC,
        CMD_READ_LINE        = 4'hE,
        CMD_WRITE_INVALIDATE = 4'hF
    } pci_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_ISSUE   = 2'h1,
        ST_XFER    = 2'h2,
        ST_RELEASE = 2'h3
    } seq_state_t;

    localparam logic [AXI_ADDR_W-1:0] OFS_TEST_CONTROL_THREE = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFS_DMA_MODE           = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFS_TEST_CONTROL_FIVE  = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] OFS_PCI_COMMAND        = 8'h0C;
    localparam logic [AXI_ADDR_W-1:0] OFS_CACHE_LINE_SIZE    = 8'h10;
    localparam logic [AXI_ADDR_W-1:0] OFS_CACHE_CONTROL      = 8'h14;
    localparam logic [AXI_ADDR_W-1:0] OFS_STATUS             = 8'h18;

    localparam int BIT_WRITE_INVALIDATE_ENABLE = 0;
    localparam int BIT_READ_MULTIPLE_ENABLE    = 2;
    localparam int BIT_READ_LINE_ENABLE        = 3;
    localparam int BURST_CODE_LO               = 6;
    localparam int BIT_BURST_EXTEND            = 2;
    localparam int BIT_MWI_MODE                = 4;
    localparam int BIT_CACHE_MODE_ENABLE       = 0;
    localparam int STAT_CMD_LO                 = 0;
    localparam int STAT_LEN_LO                 = 4;
    localparam int STAT_BUSY                   = 13;
    localparam int STAT_LINE_LO                = 16;

    localparam logic [LEN_W-1:0] BURST_BASE = 9'h002;
    localparam logic [1:0]       RESP_OKAY   = 2'h0;
    localparam logic [1:0]       RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CNT_W-1:0]  dwords;
        logic              is_write;
        logic              is_fetch;
    } xfer_req_t;

    typedef struct packed {
        logic beat;
        logic retry;
        logic disconnect;
        logic latency_expired;
    } bus_event_t;

    typedef struct packed {
        pci_cmd_t         cmd;
        logic [LEN_W-1:0] len;
    } burst_t;
endpackage

/* tb/pci_target_model.sv */
`timescale 1ns/1ns
module pci_target_model
    import cache_cmd_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       bus_req,
    input  wire logic       burst_valid,
    input  wire burst_t     burst,
    input  wire logic       slow,
    input  wire logic [1:0] inject,
    output bus_event_t      bus_ev
);
    logic [8:0] left;
    logic [1:0] pend;
    logic       ph;
    // An injected fault waits in pend until the next data phase the target takes part in
    always_ff @(posedge aclk) begin
        bus_ev <= '0;
        ph <= ~ph;
        if (inject != 2'h0) pend <= inject;
        if (!aresetn) begin
            left <= '0;
            pend <= '0;
            ph <= 1'b0;
        end else if (burst_valid) begin
            left <= burst.len;
        end else if (!bus_req) begin
            left <= '0;
        end else if (left != 9'h000 && bus_req && !(slow && ph)) begin
            pend <= '0;
            if ((inject | pend) == 2'h1) begin
                bus_ev.retry <= 1'b1;
                left <= '0;
            end else begin
                bus_ev.beat <= 1'b1;
                left <= left - 9'h001;
                bus_ev.latency_expired <= ((inject | pend) == 2'h3);
                bus_ev.disconnect <= ((inject | pend) == 2'h2);
                if ((inject | pend) == 2'h2) left <= '0;
            end
        end
    end
endmodule

/* tb/pci_cache_command_selector_tb_top.sv */
`timescale 1ns/1ns
module pci_cache_command_selector_tb_top
    import cache_cmd_pkg::*;
;
    // fl holds write-invalidate enable, cache mode, write, fetch
    typedef struct packed {
        logic [3:0] fl;
        logic [7:0] dm, ln;
        logic [8:0] fd;
        logic [7:0] a;
        logic [15:0] n;
        logic [3:0] c;
        logic [8:0] l;
    } row_t;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid, slow, awready, wready, bvalid;
    logic arready, rvalid, req_ready, bus_req, burst_valid, bus_release, xfer_done;
    logic [AXI_ADDR_W-1:0] awaddr, araddr;
    logic [31:0]           wdata, rdata;
    logic [3:0]            wstrb, s;
    logic [1:0]            bresp, rresp, inject;
    logic [8:0]            fifo_dwords;
    xfer_req_t             req;
    bus_event_t            bus_ev;
    burst_t                burst;
    int                    fail_count, n_compared, i, k;
    row_t                  rows [15];
    row_t                  r;
    assign s = {req_ready, xfer_done, bus_release, burst_valid};
    pci_cache_command_selector i_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .req_valid, .req, .req_ready,
        .fifo_dwords, .bus_ev, .bus_req, .burst_valid, .burst, .bus_release, .xfer_done
    );
    pci_target_model i_target (.aclk, .aresetn, .bus_req, .burst_valid, .burst, .slow, .inject, .bus_ev);
    task tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_compared++;
        if (!ok) begin
            fail_count++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    // Clears any one-cycle fault request on its first edge
    task await(input int b);
        k = 0;
        do begin
            @(posedge aclk);
            inject <= 2'h0;
            k++;
        end while (s[b] !== 1'b1 && k < 400);
        chk(k < 400, "handshake wait ran out");
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp === RESP_OKAY, "write response");
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    task cfg(input logic w3, input logic [7:0] dm, input logic ce, input logic [7:0] ln);
        wr(OFS_TEST_CONTROL_THREE, {7'h00, w3});
        wr(OFS_DMA_MODE, dm);
        wr(OFS_TEST_CONTROL_FIVE, 8'h00);
        wr(OFS_PCI_COMMAND, 8'h10);
        wr(OFS_CACHE_LINE_SIZE, ln);
        wr(OFS_CACHE_CONTROL, {7'h00, ce});
    endtask
    task go(input logic [7:0] a, input logic [15:0] n, input logic w, input logic f, input logic [3:0] c,
            input logic [8:0] l);
        @(posedge aclk);
        req <= '{addr: {22'h000000, a}, dwords: n, is_write: w, is_fetch: f};
        req_valid <= 1'b1;
        await(3);
        req_valid <= 1'b0;
        await(0);
        chk(burst.cmd === c && burst.len === l && bus_req === 1'b1, "burst command or length");
    endtask
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Fifteen rows plus four sequences need well under ten thousand cycles
    initial begin
        repeat (40000) @(posedge aclk);
        chk(1'b0, "watchdog expired");
        tally_and_finish();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid, slow} = '0;
        {awaddr, araddr, wdata, inject} = '0;
        req = '0;
        wstrb = 4'hF;
        fifo_dwords = 9'h100;
        fail_count = 0;
        n_compared = 0;
        rows = '{'{4'hE, 8'hC0, 8'h08, 9'h100, 8'h00, 16'h0020, 4'hF, 9'h010},
                 '{4'h6, 8'hC0, 8'h08, 9'h100, 8'h00, 16'h0010, 4'h7, 9'h008},
                 '{4'hE, 8'hC0, 8'h20, 9'h100, 8'h00, 16'h0010, 4'h7, 9'h010},
                 '{4'hE, 8'hC0, 8'h08, 9'h100, 8'h04, 16'h0010, 4'h7, 9'h001},
                 '{4'hE, 8'hC0, 8'h08, 9'h100, 8'h00, 16'h000C, 4'hF, 9'h008},
                 '{4'hE, 8'hC0, 8'h0C, 9'h100, 8'h00, 16'h0010, 4'h7, 9'h008},
                 '{4'hE, 8'hC0, 8'h08, 9'h004, 8'h00, 16'h0010, 4'h7, 9'h008},
                 '{4'hA, 8'hC0, 8'h08, 9'h100, 8'h00, 16'h0010, 4'h7, 9'h010},
                 '{4'h0, 8'hC8, 8'h08, 9'h100, 8'h00, 16'h000A, 4'hE, 9'h00A},
                 '{4'h1, 8'hC8, 8'h08, 9'h100, 8'h00, 16'h000A, 4'h6, 9'h00A},
                 '{4'h4, 8'hC4, 8'h08, 9'h100, 8'h00, 16'h0020, 4'hC, 9'h010},
                 '{4'h4, 8'hCC, 8'h08, 9'h100, 8'h00, 16'h0020, 4'hC, 9'h010},
                 '{4'h4, 8'hC8, 8'h08, 9'h100, 8'h00, 16'h0014, 4'hE, 9'h008},
                 '{4'h4, 8'hC4, 8'h08, 9'h100, 8'h00, 16'h000C, 4'h6, 9'h008},
                 '{4'hE, 8'h80, 8'h08, 9'h100, 8'h00, 16'h0020, 4'hF, 9'h008}};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 15; i++) begin
            r = rows[i];
            cfg(r.fl[3], r.dm, r.fl[2], r.ln);
            fifo_dwords <= r.fd;
            slow <= i[0];
            go(r.a, r.n, r.fl[1], r.fl[0], r.c, r.l);
            await(2);
        end
        fifo_dwords <= 9'h100;
        rd(8'h40);
        chk(rresp === RESP_SLVERR && rdata === 32'h00000000, "unmapped read answer");
        rd(OFS_CACHE_LINE_SIZE);
        chk(rdata === 32'h00000008, "line size readback");
        cfg(1'b1, 8'hC0, 1'b1, 8'h08);
        go(8'h00, 16'h0018, 1'b1, 1'b0, 4'hF, 9'h010);
        await(0);
        chk(burst.cmd === CMD_WRITE_INVALIDATE && burst.len === 9'h008, "second burst");
        await(2);
        go(8'h00, 16'h0010, 1'b1, 1'b0, 4'hF, 9'h010);
        inject <= 2'h1;
        await(1);
        await(0);
        chk(burst.cmd === CMD_WRITE_INVALIDATE && burst.len === 9'h010, "burst after retry");
        await(2);
        go(8'h00, 16'h0010, 1'b1, 1'b0, 4'hF, 9'h010);
        inject <= 2'h2;
        await(1);
        await(0);
        chk(burst.cmd === CMD_MEM_WRITE && burst.len === 9'h001, "burst after disconnect");
        await(2);
        go(8'h00, 16'h0010, 1'b1, 1'b0, 4'hF, 9'h010);
        inject <= 2'h3;
        await(1);
        await(0);
        chk(burst.cmd === CMD_WRITE_INVALIDATE && burst.len === 9'h008, "burst after time-out");
        await(2);
        tally_and_finish();
    end
endmodule
